/* inc/spc_defs.vh */
// Offsets, field positions, reset values and codes of the serial port control block
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH

`define SPC_OFS_SERIAL_CONTROL 8'h98
`define SPC_OFS_OWN_ADDRESS    8'ha0
`define SPC_OFS_ADDRESS_MASK   8'ha4
`define SPC_OFS_AUX_CONTROL    8'ha8
`define SPC_OFS_IRQ_STATUS     8'hac
`define SPC_OFS_IRQ_MASK       8'hb0
`define SPC_OFS_BIT_WRITE      8'hb4

`define SPC_SERIAL_CONTROL_RESET         8'h00
`define SPC_ADDR_RESET         8'h00
`define SPC_MASK_RESET         8'h00
`define SPC_IRQ_RESET          3'h0

`define SPC_BIT_MODE_LOW       7
`define SPC_BIT_MODE_HIGH      6
`define SPC_BIT_MP_ENABLE      5
`define SPC_BIT_RX_ENABLE      4
`define SPC_BIT_TX_NINTH       3
`define SPC_BIT_RX_NINTH       2
`define SPC_BIT_TX_DONE        1
`define SPC_BIT_RX_DONE        0

`define SPC_IRQ_RX_DONE        0
`define SPC_IRQ_TX_DONE        1
`define SPC_IRQ_FRAMING        2

`define SPC_MODE_SHIFT         2'h0
`define SPC_MODE_UART8         2'h1

`define SPC_RESP_OKAY          2'h0
`define SPC_RESP_SLVERR        2'h2

`endif

/* rtl/spc_addr_match.v */
// Masked comparison of a received address byte against the given address
`timescale 1ns/10ps
module spc_addr_match #(
  parameter W = 8
) (
  input  wire [W-1:0] rx_byte_i,     // Received address byte
  input  wire [W-1:0] own_address_i, // Individual address
  input  wire [W-1:0] address_mask_i,// Zero bits are don't-care
  output wire         hit_o          // Address matches
);

  assign hit_o = ((rx_byte_i ^ own_address_i) & address_mask_i) == {W{1'b0}}; // [RULE_11]

endmodule // spc_addr_match

/* rtl/spc_serial_control.v */
// Serial port control register, flag handling, address filter and AXI4-Lite slave
// Functional notes
// [RULE_01] Modes 2 and 3: received ninth bit is copied into rx_ninth_bit.
// [RULE_02] Mode 1 without multiprocessor enable: stop bit goes into rx_ninth_bit.
// [RULE_03] Mode 0: rx_ninth_bit is never updated by reception.
// [RULE_04] transmit_done_flag set after eighth bit in mode 0, else at stop start.
// [RULE_05] Mode 0: receive_done_flag set at end of eighth received bit.
// [RULE_06] Software clears the done flags by writing zero; hardware only sets them.
// [RULE_07] Control register resets to zero; each bit writable on its own.
// [RULE_08] Multiprocessor enable has no effect while mode 0 is selected.
// [RULE_09] Multiprocessor mode: receive_done_flag only set on matching address.
// [RULE_10] Mode 1 address filtering uses stop bit as ninth bit; needs valid stop.
// [RULE_11] Given address is own_address with zero mask bits as don't-care.
`timescale 1ns/10ps
`include "spc_defs.vh"
module spc_serial_control (
  input  wire        clk_i,           // 250 MHz clock
  input  wire        arst_n_i,        // Async reset, active low
  input  wire [7:0]  s_axi_awaddr,    // Write address
  input  wire        s_axi_awvalid,   // Write address valid
  output wire        s_axi_awready,   // Write address ready
  input  wire [31:0] s_axi_wdata,     // Write data
  input  wire [3:0]  s_axi_wstrb,     // Write byte strobes
  input  wire        s_axi_wvalid,    // Write data valid
  output wire        s_axi_wready,    // Write data ready
  output reg  [1:0]  s_axi_bresp,     // Write response
  output reg         s_axi_bvalid,    // Write response valid
  input  wire        s_axi_bready,    // Write response ready
  input  wire [7:0]  s_axi_araddr,    // Read address
  input  wire        s_axi_arvalid,   // Read address valid
  output wire        s_axi_arready,   // Read address ready
  output reg  [31:0] s_axi_rdata,     // Read data
  output reg  [1:0]  s_axi_rresp,     // Read response
  output reg         s_axi_rvalid,    // Read data valid
  input  wire        s_axi_rready,    // Read data ready
  input  wire        tx_bit8_end_i,   // Pulse: end of eighth bit sent
  input  wire        tx_stop_start_i, // Pulse: stop bit starts
  input  wire        rx_bit8_end_i,   // Pulse: end of eighth bit received
  input  wire        rx_frame_end_i,  // Pulse: frame received, modes 1-3
  input  wire [7:0]  rx_byte_i,       // Received data byte
  input  wire        rx_ninth_i,      // Ninth bit, or stop bit in mode 1
  input  wire        rx_stop_bad_i,   // Stop bit was invalid
  output wire [1:0]  port_mode_o,     // Selected mode
  output wire        rx_enable_o,     // Reception enabled
  output wire        tx_ninth_bit_o,  // Ninth bit to send
  output wire        irq_o            // Interrupt, level
);

  reg        mode_low_q;
  reg        mode_high_q;
  reg        mp_enable_q;
  reg        rx_enable_q;
  reg        tx_ninth_q;
  reg        rx_ninth_q;
  reg        tx_done_q;
  reg        rx_done_q;
  reg        framing_error_q;
  reg        framing_flag_select_q;
  reg [7:0]  own_address_q;
  reg [7:0]  address_mask_q;
  reg [2:0]  irq_status_q;
  reg [2:0]  irq_mask_q;
  reg        aw_have_q;
  reg [7:0]  aw_addr_q;
  reg        w_have_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;

  wire [1:0] mode      = {mode_low_q, mode_high_q};
  wire       mode_zero = (mode == `SPC_MODE_SHIFT);
  wire       mp_on     = mp_enable_q & ~mode_zero; // [RULE_08]
  wire       addr_hit;

  spc_addr_match #(
    .W (8)
  ) u_match (
    .rx_byte_i      (rx_byte_i),
    .own_address_i  (own_address_q),
    .address_mask_i (address_mask_q),
    .hit_o          (addr_hit)
  );

  // Ninth bit is the stop bit in mode 1, so one test covers modes 1 to 3
  wire rx_frame  = ~mode_zero & rx_frame_end_i & rx_enable_q;
  wire rx_accept = ~mp_on | (rx_ninth_i & addr_hit); // [RULE_09] [RULE_10]
  wire ri_set    = mode_zero ? (rx_bit8_end_i & rx_enable_q) // [RULE_05]
                             : (rx_frame & rx_accept);
  wire ti_set    = mode_zero ? tx_bit8_end_i : tx_stop_start_i; // [RULE_04]
  wire rb8_load  = rx_frame & rx_accept; // [RULE_01] [RULE_02] [RULE_03]
  wire fe_set    = rx_frame & rx_stop_bad_i;

  wire [7:0] serial_control_cur = {framing_flag_select_q ? framing_error_q : mode_low_q,
                         mode_high_q, mp_enable_q, rx_enable_q,
                         tx_ninth_q, rx_ninth_q, tx_done_q, rx_done_q};

  // Write side: address and data may arrive in either order
  wire wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign s_axi_awready = ~aw_have_q;
  assign s_axi_wready  = ~w_have_q;

  wire wr_serial_control = wr_fire & (aw_addr_q == `SPC_OFS_SERIAL_CONTROL) & w_strb_q[0];
  wire wr_bit  = wr_fire & (aw_addr_q == `SPC_OFS_BIT_WRITE) & w_strb_q[0];
  wire wr_own  = wr_fire & (aw_addr_q == `SPC_OFS_OWN_ADDRESS) & w_strb_q[0];
  wire wr_msk  = wr_fire & (aw_addr_q == `SPC_OFS_ADDRESS_MASK) & w_strb_q[0];
  wire wr_aux  = wr_fire & (aw_addr_q == `SPC_OFS_AUX_CONTROL) & w_strb_q[0];
  wire wr_ists = wr_fire & (aw_addr_q == `SPC_OFS_IRQ_STATUS) & w_strb_q[0];
  wire wr_imsk = wr_fire & (aw_addr_q == `SPC_OFS_IRQ_MASK) & w_strb_q[0];
  wire wr_map  = (aw_addr_q == `SPC_OFS_SERIAL_CONTROL) | (aw_addr_q == `SPC_OFS_BIT_WRITE) |
                 (aw_addr_q == `SPC_OFS_OWN_ADDRESS) | (aw_addr_q == `SPC_OFS_ADDRESS_MASK) |
                 (aw_addr_q == `SPC_OFS_AUX_CONTROL) | (aw_addr_q == `SPC_OFS_IRQ_STATUS) |
                 (aw_addr_q == `SPC_OFS_IRQ_MASK);

  // Single-bit write keeps the other seven bits as they read
  wire [7:0] bit_sel  = 8'h01 << w_data_q[2:0];
  wire [7:0] serial_control_new = wr_bit ? ((serial_control_cur & ~bit_sel) | (bit_sel & {8{w_data_q[3]}}))
                               : w_data_q[7:0]; // [RULE_07]
  wire       serial_control_wr  = wr_serial_control | wr_bit;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_have_q    <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_have_q     <= 1'b0;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SPC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_have_q) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_have_q) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `SPC_RESP_OKAY : `SPC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control fields; a hardware set in the same cycle beats a software clear
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_low_q            <= 1'b0; // [RULE_07]
      mode_high_q           <= 1'b0;
      mp_enable_q           <= 1'b0;
      rx_enable_q           <= 1'b0;
      tx_ninth_q            <= 1'b0;
      rx_ninth_q            <= 1'b0;
      tx_done_q             <= 1'b0;
      rx_done_q             <= 1'b0;
      framing_error_q       <= 1'b0;
      framing_flag_select_q <= 1'b0;
      own_address_q         <= `SPC_ADDR_RESET;
      address_mask_q        <= `SPC_MASK_RESET;
      irq_status_q          <= `SPC_IRQ_RESET;
      irq_mask_q            <= `SPC_IRQ_RESET;
    end else begin
      if (serial_control_wr) begin
        if (framing_flag_select_q) begin
          framing_error_q <= serial_control_new[`SPC_BIT_MODE_LOW] | fe_set;
        end else begin
          mode_low_q <= serial_control_new[`SPC_BIT_MODE_LOW];
        end
        mode_high_q <= serial_control_new[`SPC_BIT_MODE_HIGH];
        mp_enable_q <= serial_control_new[`SPC_BIT_MP_ENABLE];
        rx_enable_q <= serial_control_new[`SPC_BIT_RX_ENABLE];
        tx_ninth_q  <= serial_control_new[`SPC_BIT_TX_NINTH];
      end
      if (fe_set) begin
        framing_error_q <= 1'b1;
      end else if (serial_control_wr && framing_flag_select_q) begin
        framing_error_q <= serial_control_new[`SPC_BIT_MODE_LOW];
      end
      if (rb8_load) begin
        rx_ninth_q <= rx_ninth_i; // [RULE_01] [RULE_02]
      end else if (serial_control_wr) begin
        rx_ninth_q <= serial_control_new[`SPC_BIT_RX_NINTH];
      end
      if (ti_set) begin
        tx_done_q <= 1'b1; // [RULE_04]
      end else if (serial_control_wr) begin
        tx_done_q <= serial_control_new[`SPC_BIT_TX_DONE]; // [RULE_06]
      end
      if (ri_set) begin
        rx_done_q <= 1'b1; // [RULE_05] [RULE_09]
      end else if (serial_control_wr) begin
        rx_done_q <= serial_control_new[`SPC_BIT_RX_DONE]; // [RULE_06]
      end
      if (wr_own) begin
        own_address_q <= w_data_q[7:0];
      end
      if (wr_msk) begin
        address_mask_q <= w_data_q[7:0];
      end
      if (wr_aux) begin
        framing_flag_select_q <= w_data_q[0];
      end
      if (wr_imsk) begin
        irq_mask_q <= w_data_q[2:0];
      end
      irq_status_q <= (irq_status_q & ~(wr_ists ? w_data_q[2:0] : 3'h0)) |
                      {fe_set, ti_set, ri_set};
    end
  end

  // Read side: one read at a time, data from a register
  reg [31:0] rd_data;
  reg        rd_ok;
  always @* begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (s_axi_araddr == `SPC_OFS_SERIAL_CONTROL) begin
      rd_data[7:0] = serial_control_cur;
    end else if (s_axi_araddr == `SPC_OFS_OWN_ADDRESS) begin
      rd_data[7:0] = own_address_q;
    end else if (s_axi_araddr == `SPC_OFS_ADDRESS_MASK) begin
      rd_data[7:0] = address_mask_q;
    end else if (s_axi_araddr == `SPC_OFS_AUX_CONTROL) begin
      rd_data[0] = framing_flag_select_q;
    end else if (s_axi_araddr == `SPC_OFS_IRQ_STATUS) begin
      rd_data[2:0] = irq_status_q;
    end else if (s_axi_araddr == `SPC_OFS_IRQ_MASK) begin
      rd_data[2:0] = irq_mask_q;
    end else if (s_axi_araddr == `SPC_OFS_BIT_WRITE) begin
      rd_data = 32'h0000_0000;
    end else begin
      rd_ok = 1'b0;
    end
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SPC_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_ok ? `SPC_RESP_OKAY : `SPC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign port_mode_o    = mode;
  assign rx_enable_o    = rx_enable_q;
  assign tx_ninth_bit_o = tx_ninth_q;
  assign irq_o          = |(irq_status_q & irq_mask_q);

endmodule // spc_serial_control

/* testbench/spc_serial_control_chk.sv */
// Checker for bus handshakes, control updates and interrupt behaviour
`timescale 1ns/10ps
module spc_serial_control_chk (
  input logic        clk_i,           // Clock
  input logic        arst_n_i,        // Reset
  input logic        s_axi_awvalid,   // Aw valid
  input logic        s_axi_awready,   // Aw ready
  input logic        s_axi_wvalid,    // W valid
  input logic        s_axi_wready,    // W ready
  input logic        s_axi_bvalid,    // B valid
  input logic        s_axi_bready,    // B ready
  input logic [7:0]  s_axi_araddr,    // Ar addr
  input logic        s_axi_arvalid,   // Ar valid
  input logic        s_axi_arready,   // Ar ready
  input logic [31:0] s_axi_rdata,     // R data
  input logic [1:0]  s_axi_rresp,     // R resp
  input logic        s_axi_rvalid,    // R valid
  input logic        s_axi_rready,    // R ready
  input logic        tx_bit8_end_i,   // Strobe
  input logic        tx_stop_start_i, // Strobe
  input logic        rx_bit8_end_i,   // Strobe
  input logic        rx_frame_end_i,  // Strobe
  input logic [1:0]  port_mode_o,     // Mode
  input logic        rx_enable_o,     // Rx enable
  input logic        tx_ninth_bit_o,  // Ninth bit
  input logic        irq_o            // Interrupt
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic ev;
  assign ev = tx_bit8_end_i | tx_stop_start_i | rx_bit8_end_i | rx_frame_end_i;
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_r_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answered twice");
  chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_b_latency: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  chk_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == 8'h9c |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_ctl_update: assert property ($past(arst_n_i)
    && !$stable({port_mode_o, rx_enable_o, tx_ninth_bit_o}) |-> $rose(s_axi_bvalid))
    else $error("control changed without write");
  // Flags are only set by strobes; a mask write may also expose one
  chk_irq_set: assert property ($rose(irq_o)
    |-> s_axi_bvalid || $past(ev) || $past(ev, 2))
    else $error("interrupt without cause");
  chk_irq_clear: assert property ($fell(irq_o) |-> s_axi_bvalid)
    else $error("interrupt cleared by hardware");
  cov_b_stall: cover property (s_axi_bvalid && !s_axi_bready);
  cov_irq: cover property ($rose(irq_o));
  cov_frame1: cover property (rx_frame_end_i && port_mode_o == 2'h1);
endmodule // spc_serial_control_chk

bind spc_serial_control spc_serial_control_chk u_chk (
  .clk_i           (clk_i),
  .arst_n_i        (arst_n_i),
  .s_axi_awvalid   (s_axi_awvalid),
  .s_axi_awready   (s_axi_awready),
  .s_axi_wvalid    (s_axi_wvalid),
  .s_axi_wready    (s_axi_wready),
  .s_axi_bvalid    (s_axi_bvalid),
  .s_axi_bready    (s_axi_bready),
  .s_axi_araddr    (s_axi_araddr),
  .s_axi_arvalid   (s_axi_arvalid),
  .s_axi_arready   (s_axi_arready),
  .s_axi_rdata     (s_axi_rdata),
  .s_axi_rresp     (s_axi_rresp),
  .s_axi_rvalid    (s_axi_rvalid),
  .s_axi_rready    (s_axi_rready),
  .tx_bit8_end_i   (tx_bit8_end_i),
  .tx_stop_start_i (tx_stop_start_i),
  .rx_bit8_end_i   (rx_bit8_end_i),
  .rx_frame_end_i  (rx_frame_end_i),
  .port_mode_o     (port_mode_o),
  .rx_enable_o     (rx_enable_o),
  .tx_ninth_bit_o  (tx_ninth_bit_o),
  .irq_o           (irq_o)
);

/* testbench/spc_remote_station.sv */
// Remote serial station: drives receive and transmit strobes with frame data
`timescale 1ns/10ps
module spc_remote_station (
  input  logic       clk_i,            // Clock
  output logic [3:0] strobe_o = 4'h0,  // Rx end, rx bit 8, tx stop, tx bit 8
  output logic [7:0] byte_o = 8'h00,   // Received byte
  output logic       ninth_o = 1'b0,   // Ninth or stop bit
  output logic       bad_o = 1'b0      // Stop invalid
);
  // Released lines show the inverse, so a stale byte is never mistaken
  task ev(input logic [3:0] s, input logic [7:0] b, input logic n, input logic e);
    @(posedge clk_i);
    strobe_o <= s;
    byte_o   <= b;
    ninth_o  <= n;
    bad_o    <= e;
    @(posedge clk_i);
    strobe_o <= 4'h0;
    byte_o   <= ~b;
    ninth_o  <= ~n;
    bad_o    <= ~e;
  endtask
endmodule // spc_remote_station

/* testbench/tb.sv */
// Testbench: register accesses and link events against the control block
`timescale 1ns/10ps
module tb;
  localparam logic [7:0] SC = 8'h98;
  logic clk_i = 0, arst_n_i = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, rx_ninth_i, rx_stop_bad_i, rx_enable_o, tx_ninth_bit_o;
  logic tx_bit8_end_i, tx_stop_start_i, rx_bit8_end_i, rx_frame_end_i, irq_o;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, rx_byte_i;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, q;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, port_mode_o;
  int failures = 0, compares = 0;
  spc_serial_control u_spc_serial_control (
    .clk_i           (clk_i),
    .arst_n_i        (arst_n_i),
    .s_axi_awaddr    (s_axi_awaddr),
    .s_axi_awvalid   (s_axi_awvalid),
    .s_axi_awready   (s_axi_awready),
    .s_axi_wdata     (s_axi_wdata),
    .s_axi_wstrb     (s_axi_wstrb),
    .s_axi_wvalid    (s_axi_wvalid),
    .s_axi_wready    (s_axi_wready),
    .s_axi_bresp     (s_axi_bresp),
    .s_axi_bvalid    (s_axi_bvalid),
    .s_axi_bready    (s_axi_bready),
    .s_axi_araddr    (s_axi_araddr),
    .s_axi_arvalid   (s_axi_arvalid),
    .s_axi_arready   (s_axi_arready),
    .s_axi_rdata     (s_axi_rdata),
    .s_axi_rresp     (s_axi_rresp),
    .s_axi_rvalid    (s_axi_rvalid),
    .s_axi_rready    (s_axi_rready),
    .tx_bit8_end_i   (tx_bit8_end_i),
    .tx_stop_start_i (tx_stop_start_i),
    .rx_bit8_end_i   (rx_bit8_end_i),
    .rx_frame_end_i  (rx_frame_end_i),
    .rx_byte_i       (rx_byte_i),
    .rx_ninth_i      (rx_ninth_i),
    .rx_stop_bad_i   (rx_stop_bad_i),
    .port_mode_o     (port_mode_o),
    .rx_enable_o     (rx_enable_o),
    .tx_ninth_bit_o  (tx_ninth_bit_o),
    .irq_o           (irq_o)
  );
  spc_remote_station u_spc_remote_station (.clk_i(clk_i), .byte_o(rx_byte_i),
    .strobe_o({rx_frame_end_i, rx_bit8_end_i, tx_stop_start_i, tx_bit8_end_i}),
    .ninth_o(rx_ninth_i), .bad_o(rx_stop_bad_i));
  always #2 clk_i = ~clk_i;
  task finish_test;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One write or one read; ready lags so the slave must hold its answer
  task acc(input bit w, input logic [7:0] a, input logic [31:0] d);
    bit got, aw_rdy, w_rdy, ar_rdy;
    got = 0;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    for (int n = 0; n < 40 && !got; n++) begin
      // Settled values at mid-cycle are what the next rising edge samples
      @(negedge clk_i);
      aw_rdy = s_axi_awready;
      w_rdy = s_axi_wready;
      ar_rdy = s_axi_arready;
      got = w ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready;
      q = s_axi_rdata;
      rsp = w ? s_axi_bresp : s_axi_rresp;
      @(posedge clk_i);
      if (aw_rdy) s_axi_awvalid <= 0;
      if (w_rdy) s_axi_wvalid <= 0;
      if (ar_rdy) s_axi_arvalid <= 0;
      s_axi_bready <= !got && n > 0;
      s_axi_rready <= !got && n > 0;
    end
    if (!got) begin
      failures++;
      finish_test;
    end
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    acc(0, a, 0);
    chk(nm, e, q);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1;
    rc(SC, 0, "reset");
    acc(1, 8'hb4, 32'hc);
    rc(SC, 32'h10, "bit write");
    chk("rx enable", 1, rx_enable_o);
    acc(1, 8'hb0, 32'h7);
    acc(1, SC, 32'h34);
    u_spc_remote_station.ev(4'h8, 8'ha5, 0, 0);
    u_spc_remote_station.ev(4'h2, 8'h00, 0, 0);
    rc(SC, 32'h34, "mode0 ignore");
    u_spc_remote_station.ev(4'h4, 8'h3c, 0, 0);
    rc(SC, 32'h35, "mode0 rx");
    chk("irq set", 1, irq_o);
    u_spc_remote_station.ev(4'h1, 8'h00, 0, 0);
    rc(SC, 32'h37, "mode0 tx");
    acc(1, 8'hac, 32'h7);
    acc(1, SC, 32'h30);
    rc(SC, 32'h30, "ack");
    chk("irq clear", 0, irq_o);
    acc(1, SC, 32'h50);
    chk("mode1 sel", 1, port_mode_o);
    u_spc_remote_station.ev(4'h8, 8'h11, 1, 0);
    u_spc_remote_station.ev(4'h2, 8'h00, 0, 0);
    rc(SC, 32'h57, "mode1");
    acc(1, SC, 32'h9c);
    chk("mode2 sel", 2, port_mode_o);
    chk("tx ninth", 1, tx_ninth_bit_o);
    u_spc_remote_station.ev(4'h8, 8'h22, 0, 0);
    rc(SC, 32'h99, "mode2");
    acc(1, SC, 32'hd0);
    chk("mode3 sel", 3, port_mode_o);
    u_spc_remote_station.ev(4'h8, 8'h33, 1, 0);
    rc(SC, 32'hd5, "mode3");
    acc(1, 8'ha0, 32'h56);
    acc(1, 8'ha4, 32'hfc);
    acc(1, SC, 32'h70);
    u_spc_remote_station.ev(4'h8, 8'h46, 1, 0);
    u_spc_remote_station.ev(4'h8, 8'h55, 0, 1);
    rc(SC, 32'h70, "mp miss");
    u_spc_remote_station.ev(4'h8, 8'h57, 1, 0);
    rc(SC, 32'h75, "mp hit");
    rc(8'hac, 32'h7, "irq status");
    acc(1, 8'ha8, 32'h1);
    rc(SC, 32'hf5, "framing shown");
    chk("mode kept", 1, port_mode_o);
    acc(1, SC, 32'h75);
    rc(SC, 32'h75, "framing clear");
    // Reset in mid-run must bring every control bit back to zero
    arst_n_i <= 0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1;
    rc(SC, 0, "reset again");
    rc(8'ha8, 0, "aux reset");
    chk("irq reset", 0, irq_o);
    acc(1, 8'hfc, 32'h1);
    chk("wr resp", 2, rsp);
    rc(8'h9c, 0, "rd data");
    chk("rd resp", 2, rsp);
    finish_test;
  end
endmodule // tb
